// *** verilog/fifo_level_and_event_status.sv ***
// Byte buffer with level flags, fill count, data port and first event register.
// Assumes a byte-wide register access port driven by the host interface logic on mclk;
// the RF datapath supplies event pulses and error levels on the same clock.
//
// Operation
// - Threshold eight bits, ninth bit in 512 mode
// - Near-empty when count at or below threshold
// - Read-only fill count, resets to zero
// - Count bits 9 and 8 in control
// - Port write pushes, read pops, count tracks
// - Data port accesses keep address pointer
// - Bit 7 chooses set or clear
// - Event register resets to zero
// - Latch near-full event on flag rise
// - Latch near-empty event on flag rise
// - Command ending by itself sets done
// - Every 5-bit command is known; command write sets no done
// - Host writing idle sets no done
// - Transmit done after last bit sent
// - Receive end on stream end; host checks errors
// - Any listed error sets error event
// - Frame start on start pattern or subcarrier
// - Near-full when free space at or below threshold
// - Depth select: 1 gives 255, 0 gives 512
// - Clear bit empties buffer, reads zero
// - Combined flag from any enabled event
`timescale 1ns/1ps
`include "fifo_status_map.svh"

module fifo_level_and_event_status
  import fifo_status_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Register access port
  input  wire logic addr_load,
  input  wire byte_t addr_in,
  input  wire logic wr_stb,
  input  wire byte_t wr_data,
  input  wire logic rd_stb,
  output byte_t     rd_data,
  output logic      rd_valid,
  output byte_t     addr_ptr,
  // Datapath events
  input  wire logic cmd_finished,
  input  wire logic tx_last_bit_sent,
  input  wire logic rx_stream_end,
  input  wire logic rx_frame_start,
  input  wire logic [4:0] error_flags,
  // Status towards the rest of the device
  output cmd_t      running_cmd,
  output logic      near_full_flag,
  output logic      near_empty_flag,
  output logic      combined_event
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  byte_t  mem [`BUF_DEPTH];
  ptr_t   wr_ptr;
  ptr_t   rd_ptr;
  level_t buffer_fill_count;
  byte_t  buffer_threshold;
  logic   buffer_depth_select;
  logic   threshold_top_bit;
  logic [1:0] cmd_top_bits;
  logic [6:0] event_status_first;
  byte_t  event_enable;
  logic   error_seen;
  // Named so that single control bits can be picked out of the reset value
  localparam byte_t ctl_reset = `RST_CONTROL;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic hits(input byte_t a, input byte_t target);
    hits = (a == target);
  endfunction : hits

  function automatic logic cmd_known(input cmd_t c);
    cmd_known = (c <= `CMD_LAST_KNOWN);
  endfunction : cmd_known

  logic   port_wr;
  logic   port_rd;
  level_t capacity;
  level_t threshold_eff;
  logic   is_full;
  logic   is_empty;
  logic   next_near_full;
  logic   next_near_empty;

  always_comb begin
    port_wr = wr_stb && hits(addr_ptr, `ADDR_BYTE_PORT);
    port_rd = rd_stb && hits(addr_ptr, `ADDR_BYTE_PORT);
    // Depth select changed on a non-empty buffer can strand bytes above 255
    capacity = buffer_depth_select ? `CAP_SMALL : `CAP_LARGE;
    threshold_eff = buffer_depth_select ? {2'b00, buffer_threshold}
                  : {1'b0, threshold_top_bit, buffer_threshold};
    is_full = (buffer_fill_count >= capacity);
    is_empty = (buffer_fill_count == 10'h000);
    next_near_empty = (buffer_fill_count <= threshold_eff);
    next_near_full = ((capacity - buffer_fill_count) <= threshold_eff);
  end

  // ----------------------------------------
  // Address pointer
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_ptr <= 8'h00;
    end else if (addr_load) begin
      addr_ptr <= addr_in;
    end else if ((wr_stb || rd_stb) && !hits(addr_ptr, `ADDR_BYTE_PORT)) begin
      addr_ptr <= addr_ptr + 8'h01;
    end
  end

  // ----------------------------------------
  // Buffer
  // ----------------------------------------
  logic do_clear;
  logic do_push;
  logic do_pop;

  always_comb begin
    do_clear = wr_stb && hits(addr_ptr, `ADDR_BUF_CONTROL) && wr_data[`CTL_CLEAR];
    do_push = port_wr && !is_full;
    do_pop = port_rd && !is_empty;
  end

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 9'h000;
      rd_ptr <= 9'h000;
      buffer_fill_count <= 10'h000;
    end else if (do_clear) begin
      wr_ptr <= 9'h000;
      rd_ptr <= 9'h000;
      buffer_fill_count <= 10'h000;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 9'h001;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 9'h001;
      end
      if (do_push && !do_pop) begin
        buffer_fill_count <= buffer_fill_count + 10'h001;
      end else if (do_pop && !do_push) begin
        buffer_fill_count <= buffer_fill_count - 10'h001;
      end
    end
  end

  // ----------------------------------------
  // Host-written configuration
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buffer_depth_select <= ctl_reset[`CTL_DEPTH_SEL];
      threshold_top_bit <= ctl_reset[`CTL_THR_TOP];
      buffer_threshold <= `RST_THRESHOLD;
      event_enable <= `RST_ENABLES;
    end else if (wr_stb) begin
      if (hits(addr_ptr, `ADDR_BUF_CONTROL)) begin
        buffer_depth_select <= wr_data[`CTL_DEPTH_SEL];
        threshold_top_bit <= wr_data[`CTL_THR_TOP];
      end else if (hits(addr_ptr, `ADDR_THRESHOLD)) begin
        buffer_threshold <= wr_data;
      end else if (hits(addr_ptr, `ADDR_EVENT_ENABLE)) begin
        event_enable <= wr_data;
      end
    end
  end

  // ----------------------------------------
  // Command field
  // ----------------------------------------
  logic cmd_done_set;
  logic cmd_write;

  always_comb begin
    cmd_write = wr_stb && hits(addr_ptr, `ADDR_COMMAND);
    cmd_done_set = 1'b0;
    if (cmd_write) begin
      cmd_done_set = !cmd_known(wr_data[4:0]);
    end else if (cmd_finished && running_cmd != `CMD_IDLE) begin
      cmd_done_set = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      running_cmd <= `CMD_IDLE;
      cmd_top_bits <= 2'b00;
    end else if (cmd_write) begin
      cmd_top_bits <= wr_data[7:6];
      // Host idle write stops the command quietly
      running_cmd <= cmd_known(wr_data[4:0]) ? wr_data[4:0] : `CMD_IDLE;
    end else if (cmd_finished) begin
      running_cmd <= `CMD_IDLE;
    end
  end

  // ----------------------------------------
  // Level flags and event register
  // ----------------------------------------
  logic [6:0] hw_set;
  logic [6:0] host_set;
  logic [6:0] host_clr;
  logic [6:0] next_events;

  always_comb begin
    hw_set = 7'h00;
    hw_set[`EVT_NEAR_FULL] = next_near_full && !near_full_flag;
    hw_set[`EVT_NEAR_EMPTY] = next_near_empty && !near_empty_flag;
    hw_set[`EVT_CMD_DONE] = cmd_done_set;
    hw_set[`EVT_TX_DONE] = tx_last_bit_sent;
    hw_set[`EVT_RX_END] = rx_stream_end;
    hw_set[`EVT_ERROR] = (|error_flags) && !error_seen;
    hw_set[`EVT_FRAME_START] = rx_frame_start;
    host_set = 7'h00;
    host_clr = 7'h00;
    if (wr_stb && hits(addr_ptr, `ADDR_EVENT_FIRST)) begin
      if (wr_data[`EVT_SET_DIR]) begin
        host_set = wr_data[6:0];
      end else begin
        host_clr = wr_data[6:0];
      end
    end
    // Hardware events win over a host clear in the same cycle
    next_events = (event_status_first & ~host_clr) | host_set | hw_set;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      near_full_flag <= 1'b0;
      near_empty_flag <= 1'b1;
      error_seen <= 1'b0;
    end else begin
      near_full_flag <= next_near_full;
      near_empty_flag <= next_near_empty;
      error_seen <= |error_flags;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      event_status_first <= `RST_EVENTS;
      combined_event <= 1'b0;
    end else begin
      event_status_first <= next_events;
      combined_event <= |(next_events & event_enable[6:0]);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  byte_t next_rd;

  always_comb begin
    next_rd = 8'h00;
    if (hits(addr_ptr, `ADDR_COMMAND)) begin
      next_rd = {cmd_top_bits, 1'b0, running_cmd};
    end else if (hits(addr_ptr, `ADDR_BUF_CONTROL)) begin
      next_rd[`CTL_DEPTH_SEL] = buffer_depth_select;
      next_rd[`CTL_NEAR_FULL] = near_full_flag;
      next_rd[`CTL_NEAR_EMPTY] = near_empty_flag;
      next_rd[`CTL_THR_TOP] = threshold_top_bit;
      // Clear bit reads zero; top count bits only mean anything in 512 mode
      next_rd[1:0] = buffer_depth_select ? 2'b00 : buffer_fill_count[9:8];
    end else if (hits(addr_ptr, `ADDR_THRESHOLD)) begin
      next_rd = buffer_threshold;
    end else if (hits(addr_ptr, `ADDR_FILL_COUNT)) begin
      next_rd = buffer_fill_count[7:0];
    end else if (hits(addr_ptr, `ADDR_BYTE_PORT)) begin
      next_rd = mem[rd_ptr];
    end else if (hits(addr_ptr, `ADDR_EVENT_FIRST)) begin
      next_rd = {1'b0, event_status_first};
    end else if (hits(addr_ptr, `ADDR_EVENT_ENABLE)) begin
      next_rd = event_enable;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_stb;
      if (rd_stb) begin
        rd_data <= next_rd;
      end
    end
  end

endmodule : fifo_level_and_event_status

// *** verilog/fifo_status_map.svh ***
// Offsets, field positions, reset values and limits of the buffer status block.
// Included by the package and by the design; holds definitions only.
`ifndef FIFO_STATUS_MAP_SVH
`define FIFO_STATUS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_COMMAND      8'h00
`define ADDR_BUF_CONTROL  8'h02
`define ADDR_THRESHOLD    8'h03
`define ADDR_FILL_COUNT   8'h04
`define ADDR_BYTE_PORT    8'h05
`define ADDR_EVENT_FIRST  8'h06
`define ADDR_EVENT_ENABLE 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL_DEPTH_SEL   7
`define CTL_NEAR_FULL   6
`define CTL_NEAR_EMPTY  5
`define CTL_CLEAR       4
`define CTL_THR_TOP     2
`define EVT_SET_DIR     7
`define EVT_NEAR_FULL   6
`define EVT_NEAR_EMPTY  5
`define EVT_CMD_DONE    4
`define EVT_TX_DONE     3
`define EVT_RX_END      2
`define EVT_ERROR       1
`define EVT_FRAME_START 0

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RST_CONTROL     8'h00
`define RST_THRESHOLD   8'h08
`define RST_EVENTS      7'h00
`define RST_ENABLES     8'h00
`define CAP_SMALL       10'h0ff
`define CAP_LARGE       10'h200
`define CMD_IDLE        5'h00
`define CMD_LAST_KNOWN  5'h1f
`define BUF_DEPTH       512

`endif

// *** verilog/fifo_status_pkg.sv ***
// Types shared by the buffer status block.
// Assumes fifo_status_map.svh is on the include path.
package fifo_status_pkg;
  `include "fifo_status_map.svh"

  typedef logic [7:0] byte_t;
  typedef logic [9:0] level_t;
  typedef logic [8:0] ptr_t;
  typedef logic [4:0] cmd_t;
endpackage : fifo_status_pkg

// *** dv/fifo_status_checker.sv ***
// Assertions on the register port and command field of the buffer status block.
// Assumes it is bound to fifo_level_and_event_status; one clock, async reset.
`timescale 1ns/1ps
module fifo_status_checker
  import fifo_status_pkg::*;
(
  // Clock
  input wire logic  mclk,
  input wire logic  rst,
  // Port
  input wire logic  addr_load,
  input wire byte_t addr_in,
  input wire logic  wr_stb,
  input wire logic  rd_stb,
  input wire byte_t rd_data,
  input wire logic  rd_valid,
  input wire byte_t addr_ptr,
  input wire logic  cmd_finished,
  input wire cmd_t  running_cmd
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // A load in the same cycle decides the pointer, so it is left out
  sequence acc_s;
    (wr_stb || rd_stb) && !addr_load;
  endsequence
  rd_answer_a: assert property (rd_stb |=> rd_valid) else $error("no answer");
  rd_quiet_a: assert property (!rd_stb |=> !rd_valid) else $error("stray answer");
  ptr_load_a: assert property (addr_load |=> addr_ptr == $past(addr_in))
    else $error("pointer not loaded");
  port_hold_a: assert property (acc_s ##0 addr_ptr == 8'h05 |=> addr_ptr == 8'h05)
    else $error("port moved pointer");
  ptr_step_a: assert property (acc_s ##0 addr_ptr != 8'h05
    |=> addr_ptr == $past(addr_ptr) + 8'h01) else $error("pointer not stepped");
  set_dir_a: assert property (rd_stb && addr_ptr == 8'h06 |=> !rd_data[7])
    else $error("direction bit read");
  clear_zero_a: assert property (rd_stb && addr_ptr == 8'h02 |=> !rd_data[4])
    else $error("clear bit read");
  cmd_idle_a: assert property (running_cmd != 5'h00 && cmd_finished && !wr_stb
    |=> running_cmd == 5'h00) else $error("command not idle");
endmodule : fifo_status_checker

bind fifo_level_and_event_status fifo_status_checker i_fifo_status_checker (
  .mclk(mclk), .rst(rst), .addr_load(addr_load), .addr_in(addr_in), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid), .addr_ptr(addr_ptr),
  .cmd_finished(cmd_finished), .running_cmd(running_cmd));

// *** dv/host_port_model.sv ***
// Host model of the register port: optional pointer load, then one strobe.
// Assumes the block answers a read on the edge that takes the strobe.
`timescale 1ns/1ps
module host_port_model
  import fifo_status_pkg::*;
(
  // Clock
  input wire logic  mclk,
  // Requests and answer
  output logic      addr_load,
  output byte_t     addr_in,
  output logic      wr_stb,
  output byte_t     wr_data,
  output logic      rd_stb,
  input wire byte_t rd_data
);
  initial begin
    addr_load = 1'b0;
    addr_in = 8'h00;
    wr_stb = 1'b0;
    wr_data = 8'hff;
    rd_stb = 1'b0;
  end
  // Released lines show the inverse value so a stale byte never passes
  task automatic acc(input logic ld, input byte_t a, input logic w, input byte_t dw,
                     output byte_t dr);
    if (ld) begin
      @(negedge mclk);
      addr_load = 1'b1;
      addr_in = a;
    end
    @(negedge mclk);
    addr_load = 1'b0;
    addr_in = ~a;
    wr_stb = w;
    rd_stb = !w;
    wr_data = dw;
    @(negedge mclk);
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wr_data = ~dw;
    dr = rd_data;
  endtask : acc
endmodule : host_port_model

// *** dv/testbench.sv ***
// Self-checking bench for the buffer status block.
// Assumes the host model drives the port; the bench drives the datapath events.
`timescale 1ns/1ps
module testbench
  import fifo_status_pkg::*;
;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       addr_load, wr_stb, rd_stb, rd_valid;
  byte_t      addr_in, wr_data, rd_data, addr_ptr, d;
  logic [3:0] ev = 4'h0;
  logic [4:0] ef = 5'h00;
  cmd_t       running_cmd;
  logic       near_full_flag, near_empty_flag, combined_event;
  int         miscompares = 0;
  int         check_count = 0;
  int         i;
  always #2.5 mclk = ~mclk;
  fifo_level_and_event_status i_fifo_level_and_event_status (
    .mclk(mclk), .rst(rst), .addr_load(addr_load), .addr_in(addr_in), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid),
    .addr_ptr(addr_ptr), .cmd_finished(ev[3]), .tx_last_bit_sent(ev[2]),
    .rx_stream_end(ev[1]), .rx_frame_start(ev[0]), .error_flags(ef),
    .running_cmd(running_cmd), .near_full_flag(near_full_flag),
    .near_empty_flag(near_empty_flag), .combined_event(combined_event));
  host_port_model i_host_port_model (.mclk(mclk), .addr_load(addr_load), .addr_in(addr_in),
    .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data));
  task chk(input string n, input logic [9:0] s, input logic [9:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task wr(input byte_t a, input byte_t v);
    i_host_port_model.acc(1'b1, a, 1'b1, v, d);
  endtask : wr
  task rc(input byte_t a, input byte_t e);
    i_host_port_model.acc(1'b1, a, 1'b0, 8'h00, d);
    chk($sformatf("reg %h", a), 10'(d), 10'(e));
  endtask : rc
  // About 1400 cycles of traffic; the limit leaves ample room
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    rc(8'h04, 8'h00);
    rc(8'h06, 8'h00);
    chk("near empty", 10'(near_empty_flag), 10'h001);
    $display("reset test done");
    for (i = 0; i < 9; i++) i_host_port_model.acc(i == 0, 8'h05, 1'b1, 8'(i), d);
    chk("pointer", 10'(addr_ptr), 10'h005);
    rc(8'h04, 8'h09);
    chk("near empty", 10'(near_empty_flag), 10'h000);
    for (i = 0; i < 10; i++) begin
      i_host_port_model.acc(1'b0, 8'h05, 1'b0, 8'h00, d);
      if (i < 9) chk("pop", 10'(d), 10'(i));
    end
    rc(8'h04, 8'h00);
    rc(8'h06, 8'h20);
    $display("burst test done");
    wr(8'h06, 8'hff);
    rc(8'h06, 8'h7f);
    wr(8'h06, 8'h7f);
    rc(8'h06, 8'h00);
    wr(8'h06, 8'h81);
    wr(8'h06, 8'h00);
    rc(8'h06, 8'h01);
    wr(8'h08, 8'h08);
    for (i = 0; i < 9; i++) begin
      wr(8'h06, 8'h7f);
      wr(8'h00, 8'h05);
      @(negedge mclk) {ef, ev} = 9'(1 << i);
      @(negedge mclk) {ef, ev} = 9'h000;
      rc(8'h06, (i < 4) ? 8'(1 << (i + (i > 0))) : 8'h02);
      chk("command", 10'(running_cmd), (i == 3) ? 10'h000 : 10'h005);
      chk("combined", 10'(combined_event), 10'(i == 2));
    end
    wr(8'h06, 8'h7f);
    wr(8'h00, 8'h00);
    rc(8'h06, 8'h00);
    $display("event test done");
    wr(8'h02, 8'h04);
    wr(8'h03, 8'h2c);
    for (i = 0; i < 300; i++) i_host_port_model.acc(i == 0, 8'h05, 1'b1, 8'h00, d);
    rc(8'h02, 8'h65);
    rc(8'h04, 8'h2c);
    wr(8'h02, 8'h90);
    rc(8'h04, 8'h00);
    rc(8'h02, 8'ha0);
    wr(8'h06, 8'h7f);
    for (i = 0; i < 210; i++) i_host_port_model.acc(i == 0, 8'h05, 1'b1, 8'h00, d);
    rc(8'h04, 8'hd2);
    chk("near full", 10'(near_full_flag), 10'h000);
    i_host_port_model.acc(1'b0, 8'h05, 1'b1, 8'h00, d);
    rc(8'h04, 8'hd3);
    chk("near full", 10'(near_full_flag), 10'h001);
    rc(8'h06, 8'h40);
    for (i = 0; i < 45; i++) i_host_port_model.acc(i == 0, 8'h05, 1'b1, 8'h00, d);
    rc(8'h04, 8'hff);
    $display("level test done");
    final_report();
  end
endmodule : testbench
